// >>> bft_pkg.sv
// package for the breaker failure timer block
// assumes a 40 MHz pclk and a sample strobe from the relay's sampling clock
package bft_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned HALF_CYCLE_MS = 10;
  localparam int unsigned SAMPLES_PER_CYCLE = 24;
  localparam int unsigned HALF_CYCLE_SAMPLES = SAMPLES_PER_CYCLE / 2;
  localparam int unsigned HALF_CYCLE_CYCLES = CLK_HZ / 1000 * HALF_CYCLE_MS;

  // reset option encodings for non-current and external initiation
  localparam logic [1:0] RST_UC_ONLY = 2'h0;
  localparam logic [1:0] RST_UC_AND_DROP = 2'h1;
  localparam logic [1:0] RST_UC_AND_OPEN = 2'h2;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_T1_DELAY = 8'h04;
  localparam logic [7:0] REG_T2_DELAY = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_CLR = 8'h14;
  localparam logic [7:0] REG_IRQ_EN = 8'h18;

  // control register fields
  localparam int unsigned CTRL_T1_EN = 0;
  localparam int unsigned CTRL_T2_EN = 1;
  localparam int unsigned CTRL_RETRIP = 2;
  localparam int unsigned CTRL_NONSRC_LSB = 3;
  localparam int unsigned CTRL_EXT_LSB = 5;
  localparam int unsigned CTRL_DROP_PH = 7;
  localparam int unsigned CTRL_DROP_EF = 8;
  localparam int unsigned CTRL_DROP_ALL = 9;
  localparam int unsigned CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h001;

  // timer delay width and reset values in pclk cycles
  localparam int unsigned DLY_W = 32;
  localparam logic [DLY_W-1:0] T1_DELAY_RESET = 32'h0061a800;
  localparam logic [DLY_W-1:0] T2_DELAY_RESET = 32'h00c35000;

  // interrupt event bits
  localparam int unsigned EV_INIT = 0;
  localparam int unsigned EV_T1 = 1;
  localparam int unsigned EV_T2 = 2;
  localparam int unsigned EV_W = 3;

  // initiation inputs
  typedef struct packed {
    logic current_trip;
    logic sef_trip;
    logic nonsource_trip;
    logic external_trip;
  } bft_init_s;

  // undercurrent and breaker state inputs
  typedef struct packed {
    logic phase_a_uc;
    logic phase_b_uc;
    logic phase_c_uc;
    logic earth_uc;
    logic sef_uc;
    logic [2:0] pole_open;
  } bft_meas_s;

endpackage

// >>> bft_top.sv
// breaker failure supervision: two failure timers, reset selection, zero-crossing block
// assumes same-clock protection inputs, a sample strobe with a sign bit, and an APB master
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps

module bft_top
  import bft_pkg::*;
#(
  parameter int unsigned HALF_SAMPLES = HALF_CYCLE_SAMPLES
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // protection inputs
  input wire bft_init_s init_in,
  input wire bft_meas_s meas_in,
  input wire logic phase_oc_start,
  input wire logic earth_oc_start,
  input wire logic other_start,
  // current samples
  input wire logic sample_valid,
  input wire logic sample_negative,
  // outputs
  output logic retrip_out,
  output logic backtrip_out,
  output logic phase_oc_start_out,
  output logic earth_oc_start_out,
  output logic other_start_out,
  output logic zero_cross_block,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  // configuration registers
  logic [CTRL_W-1:0] ctrl_r;
  logic [DLY_W-1:0] t1_delay_r;
  logic [DLY_W-1:0] t2_delay_r;

  // failure timer state
  logic [DLY_W-1:0] t1_cnt_r;
  logic [DLY_W-1:0] t2_cnt_r;
  logic t1_run_r;
  logic t2_run_r;
  logic t1_exp_r;
  logic t2_exp_r;

  // initiation memory
  bft_init_s latched_r;
  bft_init_s init_d_r;

  // interrupt state
  logic [EV_W-1:0] irq_stat_r;
  logic [EV_W-1:0] irq_en_r;

  // zero-crossing state
  logic [7:0] zc_cnt_r;
  logic zc_sign_r;
  logic zc_block_r;

  // combinational terms
  logic any_init;
  logic all_uc;
  logic all_open;
  logic reset_ok;
  logic timer_clear;
  logic rst_cur;
  logic rst_sef;
  logic rst_non;
  logic rst_ext;
  logic bf_op;
  logic wr_acc;
  logic irq_clr_hit;
  logic [EV_W-1:0] ev;

  ////////////////////////////////////////////////////////////////////////////
  // initiation and reset conditions
  assign any_init = init_in.current_trip | init_in.sef_trip
    | init_in.nonsource_trip | init_in.external_trip;
  assign all_uc = meas_in.phase_a_uc & meas_in.phase_b_uc
    & meas_in.phase_c_uc & meas_in.earth_uc;
  assign all_open = &meas_in.pole_open;

  // fixed reset for current based initiation
  assign rst_cur = ~latched_r.current_trip | all_uc;
  // fixed reset for sensitive earth initiation
  assign rst_sef = ~latched_r.sef_trip | meas_in.sef_uc;

  // selectable reset for non-current initiation
  always_comb begin
    case (ctrl_r[CTRL_NONSRC_LSB +: 2])
      RST_UC_AND_DROP: rst_non = all_uc & ~init_in.nonsource_trip;
      RST_UC_ONLY: rst_non = all_uc;
      RST_UC_AND_OPEN: rst_non = all_uc & all_open;
      default: rst_non = all_uc & all_open; // code 3 acts as pole open
    endcase
    if (!latched_r.nonsource_trip) begin
      rst_non = 1'b1;
    end
  end

  // selectable reset for external initiation
  always_comb begin
    case (ctrl_r[CTRL_EXT_LSB +: 2])
      RST_UC_AND_DROP: rst_ext = all_uc & ~init_in.external_trip;
      RST_UC_ONLY: rst_ext = all_uc;
      RST_UC_AND_OPEN: rst_ext = all_uc & all_open;
      default: rst_ext = all_uc & all_open; // code 3 acts as pole open
    endcase
    if (!latched_r.external_trip) begin
      rst_ext = 1'b1;
    end
  end

  assign reset_ok = rst_cur & rst_sef & rst_non & rst_ext;

  // a reset only counts once every initiation has dropped
  assign timer_clear = reset_ok & ~any_init;

  ////////////////////////////////////////////////////////////////////////////
  // initiation latch: remembers which sources started the current episode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_r <= '0;
    end else if (clk_en) begin
      if ((t1_run_r || t2_run_r) && timer_clear) begin
        latched_r <= '0;
      end else begin
        latched_r <= latched_r | init_in;
      end
    end
  end

  // previous initiation levels for the new-initiation event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_d_r <= '0;
    end else if (clk_en) begin
      init_d_r <= init_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first failure timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_run_r <= 1'b0;
      t1_cnt_r <= '0;
      t1_exp_r <= 1'b0;
    end else if (clk_en) begin
      if (!ctrl_r[CTRL_T1_EN]) begin
        t1_run_r <= 1'b0;
        t1_cnt_r <= '0;
        t1_exp_r <= 1'b0;
      end else if (t1_run_r && timer_clear) begin
        t1_run_r <= 1'b0;
        t1_cnt_r <= '0;
        t1_exp_r <= 1'b0;
      end else if (any_init || t1_run_r) begin
        t1_run_r <= 1'b1;
        if (t1_cnt_r >= t1_delay_r) begin
          t1_exp_r <= 1'b1;
        end else begin
          t1_cnt_r <= t1_cnt_r + 32'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // second failure timer, started in parallel with the first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t2_run_r <= 1'b0;
      t2_cnt_r <= '0;
      t2_exp_r <= 1'b0;
    end else if (clk_en) begin
      if (!ctrl_r[CTRL_T2_EN]) begin
        t2_run_r <= 1'b0;
        t2_cnt_r <= '0;
        t2_exp_r <= 1'b0;
      end else if (t2_run_r && timer_clear) begin
        t2_run_r <= 1'b0;
        t2_cnt_r <= '0;
        t2_exp_r <= 1'b0;
      end else if (any_init || t2_run_r) begin
        t2_run_r <= 1'b1;
        if (t2_cnt_r >= t2_delay_r) begin
          t2_exp_r <= 1'b1;
        end else begin
          t2_cnt_r <= t2_cnt_r + 32'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // zero-crossing detector: counts same-sign samples after the breaker opens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zc_cnt_r <= '0;
      zc_sign_r <= 1'b0;
      zc_block_r <= 1'b0;
    end else if (clk_en) begin
      if (!all_open) begin
        zc_cnt_r <= '0;
        zc_block_r <= 1'b0;
      end else if (sample_valid) begin
        zc_sign_r <= sample_negative;
        if (zc_cnt_r == 8'h0 || sample_negative != zc_sign_r) begin
          zc_cnt_r <= 8'h1;
          zc_block_r <= 1'b0;
        end else if (zc_cnt_r >= 8'(HALF_SAMPLES)) begin
          zc_block_r <= 1'b1;
        end else begin
          zc_cnt_r <= zc_cnt_r + 8'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trip and start outputs
  assign bf_op = t1_exp_r | t2_exp_r;

  // retrip and back-trip, both held off while the subsidence block stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retrip_out <= 1'b0;
      backtrip_out <= 1'b0;
    end else if (clk_en) begin
      if (ctrl_r[CTRL_RETRIP]) begin
        retrip_out <= t1_exp_r & ~zc_block_r;
        backtrip_out <= t2_exp_r & ~zc_block_r;
      end else begin
        retrip_out <= 1'b0;
        backtrip_out <= t1_exp_r & ~zc_block_r;
      end
    end
  end

  // start outputs, withdrawn after a failure timeout when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_oc_start_out <= 1'b0;
      earth_oc_start_out <= 1'b0;
      other_start_out <= 1'b0;
    end else if (clk_en) begin
      phase_oc_start_out <= phase_oc_start
        & ~(bf_op & (ctrl_r[CTRL_DROP_PH] | ctrl_r[CTRL_DROP_ALL]));
      earth_oc_start_out <= earth_oc_start
        & ~(bf_op & (ctrl_r[CTRL_DROP_EF] | ctrl_r[CTRL_DROP_ALL]));
      other_start_out <= other_start & ~(bf_op & ctrl_r[CTRL_DROP_ALL]);
    end
  end

  // zero-crossing block flag as seen outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_cross_block <= 1'b0;
    end else if (clk_en) begin
      zero_cross_block <= zc_block_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events: new initiation, first timer expiry, second timer expiry only with retrip enabled
  assign ev[EV_INIT] = any_init & ~(|init_d_r);
  assign ev[EV_T1] = t1_exp_r & ~backtrip_out & ~retrip_out & ~zc_block_r;
  assign ev[EV_T2] = t2_exp_r & ~backtrip_out & ~zc_block_r & ctrl_r[CTRL_RETRIP];
  assign wr_acc = psel & penable & pwrite;
  assign irq_clr_hit = wr_acc & (paddr == REG_IRQ_CLR);

  // sticky status, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
    end else if (clk_en) begin
      if (irq_clr_hit) begin
        irq_stat_r <= (irq_stat_r & ~pwdata[EV_W-1:0]) | ev;
      end else begin
        irq_stat_r <= irq_stat_r | ev;
      end
    end
  end

  // level interrupt, high while an enabled status bit is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_stat_r & irq_en_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
      t1_delay_r <= T1_DELAY_RESET;
      t2_delay_r <= T2_DELAY_RESET;
    end else if (clk_en && wr_acc) begin
      case (paddr)
        REG_CTRL: ctrl_r <= pwdata[CTRL_W-1:0];
        REG_T1_DELAY: t1_delay_r <= pwdata;
        REG_T2_DELAY: t2_delay_r <= pwdata;
        default: ;
      endcase
    end
  end

  // interrupt enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= '0;
    end else if (clk_en && wr_acc && paddr == REG_IRQ_EN) begin
      irq_en_r <= pwdata[EV_W-1:0];
    end
  end

  // zero-wait answer: ready in the access phase of every transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
    end
  end

  // apb read data, latched in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable) begin
        case (paddr)
          REG_CTRL: prdata <= {22'h0, ctrl_r};
          REG_T1_DELAY: prdata <= t1_delay_r;
          REG_T2_DELAY: prdata <= t2_delay_r;
          REG_STATUS: prdata <= {25'h0, zc_block_r, backtrip_out, retrip_out,
            t2_run_r, t1_run_r, t2_exp_r, t1_exp_r};
          REG_IRQ_STAT: prdata <= {29'h0, irq_stat_r};
          REG_IRQ_CLR: prdata <= '0;
          REG_IRQ_EN: prdata <= {29'h0, irq_en_r};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

// >>> bft_properties.sv
// port checker for the breaker failure timer block
// assumes it is bound to bft_top and that pclk is the only clock
`timescale 1ns/1ps
module bft_properties
  import bft_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // protection side
  input wire bft_meas_s meas_in,
  input wire logic phase_oc_start,
  input wire logic earth_oc_start,
  input wire logic other_start,
  input wire logic retrip_out,
  input wire logic backtrip_out,
  input wire logic phase_oc_start_out,
  input wire logic earth_oc_start_out,
  input wire logic other_start_out,
  input wire logic zero_cross_block
);
  ////////////////////////////////////////
  // one clock domain, reset disables all
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  // apb answer timing and refusal
  a_ready_setup: assert property (s_setup |=> s_answer) else $error("pready not one pulse");
  a_ready_cause: assert property (pready |-> $past(psel && !penable)) else $error("stray pready");
  a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad slverr");
  // zero crossing blocks trips and needs open poles
  a_zc_blocks: assert property (zero_cross_block && $past(zero_cross_block) |->
    !retrip_out && !backtrip_out) else $error("trip while blocked");
  a_zc_open: assert property (zero_cross_block |-> $past(&meas_in.pole_open, 2))
    else $error("block with pole closed");
  // gated starts never exceed their source
  a_ph_gate: assert property (!phase_oc_start && clk_en |=> !phase_oc_start_out)
    else $error("phase start leaked");
  a_ea_gate: assert property (!earth_oc_start && clk_en |=> !earth_oc_start_out)
    else $error("earth start leaked");
  a_oth_gate: assert property (!other_start && clk_en |=> !other_start_out)
    else $error("other start leaked");
endmodule

bind bft_top bft_properties i_bft_properties (.pclk, .presetn, .clk_en, .psel, .penable,
  .prdata, .pready, .pslverr, .meas_in, .phase_oc_start, .earth_oc_start, .other_start,
  .retrip_out, .backtrip_out, .phase_oc_start_out, .earth_oc_start_out, .other_start_out,
  .zero_cross_block);

// >>> bft_partner.sv
// model of the current sampler that feeds the block
// assumes pclk and presetn from the bench; sign pattern chosen by the bench
`timescale 1ns/1ps
module bft_partner (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // hold one sign instead of alternating
  input wire logic same_sign,
  // sample stream
  output logic sample_valid,
  output logic sample_negative
);
  logic [1:0] div_r;
  logic neg_r;
  // one sample every fourth cycle, sign flips per sample unless held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      sample_valid <= 1'b0;
      neg_r <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      sample_valid <= (div_r == 2'h3);
      if (div_r == 2'h3 && !same_sign) neg_r <= !neg_r;
    end
  end
  // outside a strobe the sign line toggles so stale values are not trusted
  assign sample_negative = sample_valid ? neg_r : div_r[0];
endmodule

// >>> bft_tb_top.sv
// self-checking bench for the breaker failure timer block
// assumes bft_top, bft_partner and the bound checker are compiled first
`timescale 1ns/1ps
module bft_tb_top
  import bft_pkg::*;
;
  localparam int HS = 4;
  localparam int LAT = 3;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic same_sign = 0, phase_oc_start = 0, earth_oc_start = 0, other_start = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, sample_valid, sample_negative, irq;
  logic retrip_out, backtrip_out, zero_cross_block;
  logic phase_oc_start_out, earth_oc_start_out, other_start_out;
  logic [2:0] drop_tab [3] = '{3'h3, 3'h5, 3'h0};
  bft_init_s init_in = '0;
  bft_meas_s meas_in = '0;
  int failures = 0, comparisons = 0, n, d;

  ////////////////////////////////////////
  // clock, design and sampler
  always #12.5 pclk = !pclk;
  bft_top #(.HALF_SAMPLES(HS)) i_bft_top (.pclk, .presetn, .clk_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .init_in, .meas_in,
    .phase_oc_start, .earth_oc_start, .other_start, .sample_valid, .sample_negative,
    .retrip_out, .backtrip_out, .phase_oc_start_out, .earth_oc_start_out,
    .other_start_out, .zero_cross_block, .irq);
  bft_partner i_bft_partner (.pclk, .presetn, .same_sign, .sample_valid, .sample_negative);

  ////////////////////////////////////////
  // model: reset allowed once inits are low
  function automatic bit resets(int sel, bit uc, bit open3);
    return uc && (sel < 2 || open3);
  endfunction
  // compare and count
  task check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, entered just after an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // count edges until zc/retrip/backtrip bit b is seen high
  task wait_hi(input int b, input int lim);
    logic [2:0] v;
    begin
      n = 0;
      v = 3'h0;
      while (v[b] !== 1'b1 && n < lim) begin
        @(posedge pclk);
        n++;
        v = {zero_cross_block, retrip_out, backtrip_out};
      end
    end
  endtask
  // drop all inits and meet every reset condition
  task settle;
    init_in <= '0;
    meas_in <= '1;
    repeat (4) @(posedge pclk);
    meas_in <= '0;
    @(posedge pclk);
  endtask
  task give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////
  // watchdog
  initial begin
    #(25 * 20000);
    failures++;
    give_verdict;
  end
  // main sequence
  initial begin
    void'($urandom(32'h0eb35d20));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, REG_CTRL, 0);
    check(rd, 32'(CTRL_RESET));
    apb(0, REG_T1_DELAY, 0);
    check(rd, T1_DELAY_RESET);
    apb(0, REG_T2_DELAY, 0);
    check(rd, T2_DELAY_RESET);
    apb(0, 8'h40, 0);
    check({err, rd}, 33'h100000000);
    // simple scheme with random delay
    d = 5 + $urandom % 16;
    apb(1, REG_T1_DELAY, d);
    apb(1, REG_IRQ_EN, 32'h2);
    init_in.current_trip <= 1'b1;
    wait_hi(0, 200);
    check(n, d + LAT);
    check(retrip_out, 0);
    apb(0, REG_IRQ_STAT, 0);
    check({rd, irq}, 33'h7);
    apb(0, REG_STATUS, 0);
    check(rd, 32'h25);
    settle;
    check(backtrip_out, 0);
    apb(1, REG_IRQ_EN, 0);
    repeat (2) @(posedge pclk);
    check(irq, 0);
    apb(1, REG_IRQ_EN, 32'h2);
    repeat (2) @(posedge pclk);
    check(irq, 1);
    apb(1, REG_IRQ_CLR, 32'h3);
    repeat (2) @(posedge pclk);
    check(irq, 0);
    // retrip plus delayed backtrip, sensitive earth reset
    apb(1, REG_CTRL, 32'h7);
    apb(1, REG_T2_DELAY, d + 8);
    init_in.sef_trip <= 1'b1;
    wait_hi(1, 200);
    check({n, backtrip_out}, {d + LAT, 1'b0});
    wait_hi(0, 200);
    check(n, 8);
    apb(0, REG_IRQ_STAT, 0);
    check(rd, 32'h7);
    init_in <= '0;
    meas_in.sef_uc <= 1'b1;
    repeat (4) @(posedge pclk);
    check({retrip_out, backtrip_out}, 0);
    settle;
    // current trip: all four undercurrents reset, three do not
    apb(1, REG_CTRL, 32'h1);
    init_in.current_trip <= 1'b1;
    repeat (3) @(posedge pclk);
    init_in <= '0;
    meas_in <= 8'hf0;
    wait_hi(0, d + 8);
    check(backtrip_out, 0);
    meas_in <= '0;
    init_in.current_trip <= 1'b1;
    wait_hi(0, 200);
    check(n, d + LAT);
    settle;
    init_in.current_trip <= 1'b1;
    repeat (3) @(posedge pclk);
    init_in <= '0;
    meas_in <= 8'he0;
    wait_hi(0, 200);
    check(n, d + LAT - 3);
    settle;
    // every reset option for non-current and external initiation
    for (int s = 0; s < 4; s++) begin
      for (int x = 0; x < 2; x++) begin
        apb(1, REG_CTRL, (s << (x ? CTRL_EXT_LSB : CTRL_NONSRC_LSB)) | 1);
        if (x) init_in.external_trip <= 1'b1;
        else init_in.nonsource_trip <= 1'b1;
        repeat (2) @(posedge pclk);
        init_in <= '0;
        meas_in <= 8'hf0;
        wait_hi(0, d + 8);
        check(backtrip_out, !resets(s, 1, 0));
        settle;
      end
    end
    // start removal after timeout, one setting at a time
    for (int b = 0; b < 3; b++) begin
      apb(1, REG_CTRL, 1 | (1 << (CTRL_DROP_PH + b)));
      {phase_oc_start, earth_oc_start, other_start} <= 3'h7;
      init_in.current_trip <= 1'b1;
      repeat (3) @(posedge pclk);
      check({phase_oc_start_out, earth_oc_start_out, other_start_out}, 7);
      wait_hi(0, 200);
      repeat (2) @(posedge pclk);
      check({phase_oc_start_out, earth_oc_start_out, other_start_out}, drop_tab[b]);
      settle;
    end
    // clock enable low freezes a running timer for ten cycles
    init_in.current_trip <= 1'b1;
    repeat (2) @(posedge pclk);
    clk_en <= 1'b0;
    repeat (10) @(posedge pclk);
    clk_en <= 1'b1;
    wait_hi(0, 200);
    check(n, d + 1);
    settle;
    // zero crossing only with all poles open, blocks trips until sign changes
    apb(1, REG_CTRL, 32'h1);
    same_sign <= 1'b1;
    init_in.current_trip <= 1'b1;
    wait_hi(2, 60);
    check(zero_cross_block, 0);
    meas_in.pole_open <= 3'h7;
    wait_hi(2, 60);
    repeat (2) @(posedge pclk);
    check({zero_cross_block, retrip_out, backtrip_out}, 4);
    same_sign <= 1'b0;
    wait_hi(0, 60);
    check(backtrip_out, 1);
    settle;
    give_verdict;
  end
endmodule
